// file: bench/mps_motor_model.sv
// motor stand-in: run spins it, stop brings it to rest
`timescale 1ns/10ps
module mps_motor_model
(
	// clock
	input  wire logic clock,
	// orders and firing
	input  wire logic run_cmd,
	input  wire logic stop_cmd,
	input  wire logic heat_inject,
	input  wire logic firing_no_rotation,
	// shaft state
	output logic      motor_stopped
);
	initial motor_stopped = 1'b0;
	always @(posedge clock)
		if (run_cmd || (heat_inject && !firing_no_rotation))
			motor_stopped <= 1'b0;
		else if (stop_cmd)
			motor_stopped <= 1'b1;
endmodule : mps_motor_model

// file: bench/mps_preheat_seq_asserts.sv
// port assertions for the preheat sequencer
`timescale 1ns/10ps
module mps_preheat_seq_asserts
	import mps_pkg::*;
#(
	parameter longint TICKS_PER_MIN = CYCLES_PER_MIN
)
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// operator inputs
	input  wire logic       motor_stopped,
	input  wire logic       stop_terminal,
	input  wire logic       run_cmd,
	input  wire logic       stop_cmd,
	// heating outputs
	input  wire logic       preheating_indication,
	input  wire logic       heat_inject,
	input  wire logic [6:0] preheat_current_level,
	input  wire logic       thermal_monitor_enable,
	input  wire logic       firing_no_rotation
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	property p_start;
		$rose(heat_inject) |-> $past(motor_stopped && stop_terminal);
	endproperty
	a_start: assert property (p_start) else $error("heat began unqualified");
	property p_moving;
		!motor_stopped |=> !heat_inject;
	endproperty
	a_moving: assert property (p_moving) else $error("heat with motor moving");
	property p_end;
		heat_inject && (run_cmd || stop_cmd) |=> !heat_inject;
	endproperty
	a_end: assert property (p_end) else $error("heat kept after order");
	property p_rearm;
		$fell(heat_inject) |-> !heat_inject [*3];
	endproperty
	a_rearm: assert property (p_rearm) else $error("heat resumed at once");
	property p_therm;
		heat_inject |-> !thermal_monitor_enable;
	endproperty
	a_therm: assert property (p_therm) else $error("thermal on during heat");
	property p_norot;
		firing_no_rotation == heat_inject;
	endproperty
	a_norot: assert property (p_norot) else $error("firing pattern mismatch");
	property p_ind;
		$rose(heat_inject) |-> $past(preheating_indication) && preheating_indication;
	endproperty
	a_ind: assert property (p_ind) else $error("indication late");
	property p_level;
		preheat_current_level <= 7'h64;
	endproperty
	a_level: assert property (p_level) else $error("level above max");
endmodule : mps_preheat_seq_asserts

bind mps_preheat_seq mps_preheat_seq_asserts #(.TICKS_PER_MIN(TICKS_PER_MIN)) chk_u
(
	.clock(clock), .rst_b(rst_b), .motor_stopped(motor_stopped),
	.stop_terminal(stop_terminal), .run_cmd(run_cmd), .stop_cmd(stop_cmd),
	.preheating_indication(preheating_indication), .heat_inject(heat_inject),
	.preheat_current_level(preheat_current_level),
	.thermal_monitor_enable(thermal_monitor_enable), .firing_no_rotation(firing_no_rotation)
);

// file: bench/mps_preheat_seq_tb.sv
// self-checking bench for the preheat sequencer
`timescale 1ns/10ps
module mps_preheat_seq_tb
	import mps_pkg::*;
;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
	logic        clock = 1'b0, rst_b, psel, penable, pwrite, pready, pslverr, serr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        stopped, st, run, stop, aux3, aux4, ind, heat, therm, norot, prof;
	logic [15:0] cmd;
	logic [6:0]  lvl;
	int          err_count = 0;
	int          n_tests = 0;
	always #25 clock = ~clock;
	mps_preheat_seq #(.TICKS_PER_MIN(10)) dut_u
	(
		.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .motor_stopped(stopped), .stop_terminal(st), .run_cmd(run),
		.stop_cmd(stop), .aux_input_three(aux3), .aux_input_four(aux4),
		.command_word(cmd), .preheating_indication(ind), .heat_inject(heat),
		.preheat_current_level(lvl), .thermal_monitor_enable(therm),
		.firing_no_rotation(norot), .control_profile_select(prof)
	);
	mps_motor_model motor_u
	(
		.clock(clock), .run_cmd(run), .stop_cmd(stop), .heat_inject(heat),
		.firing_no_rotation(norot), .motor_stopped(stopped)
	);
	task automatic conclude;
		if (err_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_heat(input int lim);
		for (int i = 0; i < lim && heat !== 1'b1; i++)
			@(posedge clock);
	endtask : wait_heat
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, st, run, stop, aux3, aux4, cmd} = '0;
		rst_b = 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		apb(1'b0, ADDR_DELAY, 32'h0);
		`CHK("delay_hidden", 32'h0, rd)
		apb(1'b1, ADDR_CONFIG, 32'h1);
		apb(1'b0, ADDR_DELAY, 32'h0);
		`CHK("delay_rst", 32'h5, rd)
		`CHK("prof_rst", PROFILE_TORQUE, prof)
		apb(1'b0, 8'h14, 32'h0);
		`CHK("unmapped", 1'b1, serr)
		apb(1'b1, ADDR_LEVEL, 32'hC8);
		apb(1'b0, ADDR_LEVEL, 32'h0);
		`CHK("level_max", 32'h64, rd)
		`CHK("level_out", 7'h64, lvl)
		apb(1'b1, ADDR_DELAY, 32'h3E8);
		apb(1'b0, ADDR_DELAY, 32'h0);
		`CHK("delay_max", 32'h3E7, rd)
		apb(1'b1, ADDR_CONFIG, 32'h101);
		@(posedge clock);
		`CHK("prof_volt", PROFILE_VOLTAGE, prof)
		apb(1'b1, ADDR_DELAY, 32'h1);
		apb(1'b1, ADDR_RESTART, 32'h2);
		apb(1'b1, ADDR_CONFIG, 32'h1);
		st <= 1'b1;
		stop <= 1'b1;
		aux3 <= 1'b1;
		@(posedge clock);
		stop <= 1'b0;
		repeat (4) @(posedge clock);
		`CHK("ind_wait", 2'b10, {ind, heat})
		repeat (11) @(posedge clock);
		`CHK("heat_early", 1'b0, heat)
		wait_heat(20);
		`CHK("heat_on", 4'hB, {heat, therm, stopped, lvl == 7'h64})
		aux3 <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK("src_low", 1'b0, heat)
		aux3 <= 1'b1;
		wait_heat(10);
		stop <= 1'b1;
		repeat (2) @(posedge clock);
		`CHK("stop_end", 1'b0, heat)
		stop <= 1'b0;
		repeat (6) @(posedge clock);
		`CHK("rearm", 1'b0, heat)
		aux3 <= 1'b0;
		repeat (2) @(posedge clock);
		aux3 <= 1'b1;
		wait_heat(10);
		run <= 1'b1;
		repeat (2) @(posedge clock);
		`CHK("run_end", 2'b00, {heat, stopped})
		{run, aux3} <= '0;
		apb(1'b1, ADDR_DELAY, 32'h0);
		apb(1'b1, ADDR_RESTART, 32'h0);
		for (int k = 0; k < 9; k++)
		begin
			apb(1'b1, ADDR_CONFIG, k < 5 ? 32'h3 | 32'(k << 4) : k < 6 ? 32'h2 :
				32'h1 | (32'h200 << (k - 6)));
			run <= 1'b1;
			@(posedge clock);
			run <= 1'b0;
			stop <= 1'b1;
			@(posedge clock);
			stop <= 1'b0;
			cmd <= k < 5 ? 16'h0800 << k : 16'h0;
			aux4 <= k == 5;
			aux3 <= k > 5;
			wait_heat(10);
			`CHK("src", {k < 6, k < 6}, {heat, ind})
			{cmd, aux3, aux4} <= '0;
		end
		conclude();
	end
	initial
	begin
		repeat (3000) @(posedge clock);
		err_count++;
		conclude();
	end
endmodule : mps_preheat_seq_tb

// file: verilog/mps_minute_timer.sv
// minute-resolution down timer restarted by a pulse
`timescale 1ns/10ps
module mps_minute_timer
	import mps_pkg::*;
#(
	parameter longint TICKS_PER_MIN = CYCLES_PER_MIN
)
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// control
	input  wire logic       restart,
	input  wire logic [9:0] minutes,
	// status
	output logic            expired
);

	logic [31:0] tick_ff;
	logic [9:0]  left_ff;
	logic        run_ff;

	// sub-minute prescaler, realigned on restart
	always_ff @(posedge clock)
	begin
		if (!rst_b || restart)
			tick_ff <= 32'h0;
		else if (run_ff && left_ff != 10'h0)
		begin
			if (tick_ff == 32'(TICKS_PER_MIN - 1))
				tick_ff <= 32'h0;
			else
				tick_ff <= tick_ff + 32'h1;
		end
	end

	// remaining minutes
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			left_ff <= 10'h0;
			run_ff  <= 1'b0;
		end
		else if (restart)
		begin
			left_ff <= minutes;
			run_ff  <= 1'b1;
		end
		else if (run_ff && left_ff != 10'h0 && tick_ff == 32'(TICKS_PER_MIN - 1))
			left_ff <= left_ff - 10'h1;
	end

	assign expired = run_ff && left_ff == 10'h0;

endmodule : mps_minute_timer

// file: verilog/mps_pkg.sv
// package of constants for the motor preheat sequencer
package mps_pkg;

	// apb register byte offsets
	localparam logic [7:0] ADDR_CONFIG   = 8'h00;
	localparam logic [7:0] ADDR_DELAY    = 8'h04;
	localparam logic [7:0] ADDR_LEVEL    = 8'h08;
	localparam logic [7:0] ADDR_RESTART  = 8'h0C;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;

	// config register field positions
	localparam int CFG_SRC_LSB     = 0;
	localparam int CFG_VBIT_LSB    = 4;
	localparam int CFG_PROFILE_BIT = 8;
	localparam int CFG_CASCADE_BIT = 9;
	localparam int CFG_DELTA_BIT   = 10;
	localparam int CFG_TWOWIRE_BIT = 11;

	// source select codes
	typedef enum logic [1:0]
	{
		SRC_NONE    = 2'b00,
		SRC_AUX3    = 2'b01,
		SRC_AUX4    = 2'b10,
		SRC_VIRTUAL = 2'b11
	} mps_src_type;

	// control profile codes
	localparam logic PROFILE_TORQUE  = 1'b0;
	localparam logic PROFILE_VOLTAGE = 1'b1;

	// reset values, limits and command bit base
	localparam logic [9:0]  RST_DELAY_MIN   = 10'h005;
	localparam logic [6:0]  RST_LEVEL_PCT   = 7'h00;
	localparam logic [9:0]  MAX_DELAY_MIN   = 10'h3E7;
	localparam logic [6:0]  MAX_LEVEL_PCT   = 7'h64;
	localparam logic [2:0]  RST_VBIT        = 3'h0;
	localparam logic [3:0]  CMD_VBIT_BASE   = 4'hB;

	// timing: one minute at the 20 MHz clock
	localparam int MINUTE_S          = 60;
	localparam int CLOCK_HZ          = 20_000_000;
	localparam longint CYCLES_PER_MIN = longint'(MINUTE_S) * longint'(CLOCK_HZ);

endpackage : mps_pkg

// file: verilog/mps_preheat_seq.sv
// preheat sequencer top with apb register file
`timescale 1ns/10ps
module mps_preheat_seq
	import mps_pkg::*;
#(
	parameter longint TICKS_PER_MIN = CYCLES_PER_MIN
)
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// motor and operator inputs
	input  wire logic        motor_stopped,
	input  wire logic        stop_terminal,
	input  wire logic        run_cmd,
	input  wire logic        stop_cmd,
	input  wire logic        aux_input_three,
	input  wire logic        aux_input_four,
	input  wire logic [15:0] command_word,
	// heating outputs
	output logic             preheating_indication,
	output logic             heat_inject,
	output logic      [6:0]  preheat_current_level,
	output logic             thermal_monitor_enable,
	output logic             firing_no_rotation,
	output logic             control_profile_select
);

	typedef enum logic [1:0]
	{
		ST_IDLE    = 2'b00,
		ST_WAIT    = 2'b01,
		ST_HEAT    = 2'b10,
		ST_REARM   = 2'b11
	} mps_state_type;

	mps_state_type state_ff;
	mps_state_type nxt_state;

	logic [1:0] src_ff;
	logic [2:0] vbit_ff;
	logic       profile_ff;
	logic       cascade_ff;
	logic       delta_ff;
	logic       twowire_ff;
	logic [9:0] delay_ff;
	logic [6:0] level_ff;
	logic [9:0] restart_ff;
	logic       stopped_d_ff;
	logic       tpr_expired;
	logic       tbs_expired;
	logic       stop_edge;
	logic       request;
	logic       barred;
	logic       conditions;
	logic       end_cond;
	logic       wr_en;
	logic       rd_en;
	logic [31:0] nxt_prdata;

	// decode a byte address to a known register
	function automatic logic addr_valid(input logic [7:0] a);
		addr_valid = (a == ADDR_CONFIG) || (a == ADDR_DELAY) || (a == ADDR_LEVEL) ||
			(a == ADDR_RESTART) || (a == ADDR_STATUS);
	endfunction : addr_valid

	assign wr_en   = psel && penable && pwrite && addr_valid(paddr);
	assign rd_en   = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_valid(paddr);

	// config register
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			src_ff     <= SRC_NONE;
			vbit_ff    <= RST_VBIT;
			profile_ff <= PROFILE_TORQUE;
			cascade_ff <= 1'b0;
			delta_ff   <= 1'b0;
			twowire_ff <= 1'b0;
		end
		else if (wr_en && paddr == ADDR_CONFIG)
		begin
			src_ff     <= pwdata[CFG_SRC_LSB +: 2];
			vbit_ff    <= (pwdata[CFG_VBIT_LSB +: 3] > 3'h4) ? 3'h4 : pwdata[CFG_VBIT_LSB +: 3];
			profile_ff <= pwdata[CFG_PROFILE_BIT];
			cascade_ff <= pwdata[CFG_CASCADE_BIT];
			delta_ff   <= pwdata[CFG_DELTA_BIT];
			twowire_ff <= pwdata[CFG_TWOWIRE_BIT];
		end
	end

	// preheat delay and level, writable only with a source assigned
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			delay_ff <= RST_DELAY_MIN;
			level_ff <= RST_LEVEL_PCT;
		end
		else if (wr_en && src_ff != SRC_NONE)
		begin
			if (paddr == ADDR_DELAY)
				delay_ff <= (pwdata[9:0] > MAX_DELAY_MIN) ? MAX_DELAY_MIN : pwdata[9:0];
			if (paddr == ADDR_LEVEL)
				level_ff <= (pwdata[6:0] > MAX_LEVEL_PCT || pwdata[31:7] != 25'h0) ?
					MAX_LEVEL_PCT : pwdata[6:0];
		end
	end

	// restart delay in minutes
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			restart_ff <= 10'h0;
		else if (wr_en && paddr == ADDR_RESTART)
			restart_ff <= (pwdata[9:0] > MAX_DELAY_MIN) ? MAX_DELAY_MIN : pwdata[9:0];
	end

	// read data, registered in the setup phase
	always_comb
	begin
		nxt_prdata = 32'h0;
		case (paddr)
			ADDR_CONFIG:
				nxt_prdata = {20'h0, twowire_ff, delta_ff, cascade_ff, profile_ff,
					1'b0, vbit_ff, 2'b00, src_ff};
			ADDR_DELAY:
				nxt_prdata = (src_ff != SRC_NONE) ? {22'h0, delay_ff} : 32'h0;
			ADDR_LEVEL:
				nxt_prdata = (src_ff != SRC_NONE) ? {25'h0, level_ff} : 32'h0;
			ADDR_RESTART:
				nxt_prdata = {22'h0, restart_ff};
			ADDR_STATUS:
				nxt_prdata = {26'h0, state_ff, tbs_expired, tpr_expired,
					heat_inject, preheating_indication};
			default:
				nxt_prdata = 32'h0;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			prdata <= 32'h0;
		else if (rd_en)
			prdata <= nxt_prdata;
	end

	// stop edge restarts both timers together
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			stopped_d_ff <= 1'b0;
		else
			stopped_d_ff <= motor_stopped;
	end

	assign stop_edge = motor_stopped && !stopped_d_ff;

	mps_minute_timer #(
		.TICKS_PER_MIN (TICKS_PER_MIN)
	) u_tpr (
		.clock   (clock),
		.rst_b   (rst_b),
		.restart (stop_edge),
		.minutes (delay_ff),
		.expired (tpr_expired)
	);

	mps_minute_timer #(
		.TICKS_PER_MIN (TICKS_PER_MIN)
	) u_tbs (
		.clock   (clock),
		.rst_b   (rst_b),
		.restart (stop_edge),
		.minutes (restart_ff),
		.expired (tbs_expired)
	);

	// selected request source
	always_comb
	begin
		case (src_ff)
			SRC_AUX3:    request = aux_input_three;
			SRC_AUX4:    request = aux_input_four;
			SRC_VIRTUAL: request = command_word[CMD_VBIT_BASE + {1'b0, vbit_ff}];
			default:     request = 1'b0;
		endcase
	end

	assign barred     = cascade_ff || delta_ff || twowire_ff;
	assign conditions = motor_stopped && tpr_expired && tbs_expired &&
		stop_terminal && request && !barred;
	assign end_cond   = !request || run_cmd || stop_cmd || barred || !motor_stopped;

	// sequencer
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (request && !barred && motor_stopped && !run_cmd && !stop_cmd)
					nxt_state = ST_WAIT;
			ST_WAIT:
				if (end_cond)
					nxt_state = ST_REARM;
				else if (conditions)
					nxt_state = ST_HEAT;
			ST_HEAT:
				if (end_cond || !stop_terminal)
					nxt_state = ST_REARM;
			ST_REARM:
				if (!request && !run_cmd && !stop_cmd)
					nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// outputs
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			preheat_current_level <= RST_LEVEL_PCT;
		else
			preheat_current_level <= level_ff;
	end

	assign preheating_indication  = state_ff == ST_WAIT || state_ff == ST_HEAT;
	assign heat_inject            = state_ff == ST_HEAT;
	assign thermal_monitor_enable = state_ff != ST_HEAT;
	assign firing_no_rotation     = state_ff == ST_HEAT;
	assign control_profile_select = profile_ff;

endmodule : mps_preheat_seq
